//--- hw/flash_result_pkg.sv
package flash_result_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on the register bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_KEY = 8'h04;
    localparam logic [7:0] OFF_ARRAY_SELECT = 8'h08;
    localparam logic [7:0] OFF_SOURCE_ADDR = 8'h0C;
    localparam logic [7:0] OFF_DEST_ADDR = 8'h10;
    localparam logic [7:0] OFF_ERASE_BLOCK = 8'h14;
    localparam logic [7:0] OFF_RESULT = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_PROGRAM_BIT = 0;
    localparam int CTRL_ERASE_BIT = 1;

    // ------------------------------------------------------------
    // Result byte field positions
    // ------------------------------------------------------------
    localparam int RES_PROTECT_BIT = 6;
    localparam int RES_EXEC_BIT = 5;
    localparam int RES_KEY_BIT = 4;
    localparam int RES_BLOCK_BIT = 3;
    localparam int RES_SOURCE_BIT = 2;
    localparam int RES_DEST_BIT = 1;
    localparam int RES_SF_BIT = 0;

    // Interrupt status bits: operation finished, operation failed.
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;

    // ------------------------------------------------------------
    // Check values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_VALID = 8'h5A;
    localparam logic [7:0] ARRAY_SELECT_BOOT = 8'hAA;
    localparam logic [7:0] ALIGN_LOW_A = 8'h00;
    localparam logic [7:0] ALIGN_LOW_B = 8'h80;
    localparam logic [7:0] ERASE_BLOCK_COUNT = 8'h10;
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_LIMIT = 32'h0003_FFFF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_RUN = 4'b0100,
        ST_DONE = 4'b1000
    } seq_state_t;

endpackage

//--- hw/addr_window_check.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Address window check
// ------------------------------------------------------------
// Flags whether an address lies inside the flash memory area. Used once
// for the data source and once for the programming destination.
module addr_window_check
    import flash_result_pkg::*;
(
    input wire logic [31:0] addr,
    output logic in_flash
);

    // Both bounds are inclusive.
    always_comb begin
        in_flash = (addr >= FLASH_BASE) && (addr <= FLASH_LIMIT);
    end

endmodule

//--- hw/flash_result_flags.sv
// Function
// - Program: key not 5A sets bit 4.
// - Program: source outside flash sets bit 2.
// - Program: destination outside flash sets bit 1.
// - Program: destination not 128-byte aligned sets bit 1.
// - Program: bit 0 reports success or failure.
// - Erase uses its own result byte layout.
// - Erase: bit 6 mirrors protection error flag.
// - Erase: array failure or config change sets bit 5.
// - Boot array selected: erase refused, bit 5.
// - Erase: bit 0 reports success or failure.
// - Erase: key not 5A sets bit 4.
// - Erase: block number out of range sets bit 3.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

module flash_result_flags
    import flash_result_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic protect_error_flag,
    input wire logic flash_done,
    input wire logic flash_fail,
    output logic flash_start,
    output logic flash_erase,
    output logic [31:0] flash_dest,
    output logic [31:0] flash_src,
    output logic [7:0] flash_block,
    output logic [7:0] prog_erase_result_flags,
    output logic busy,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All state of the block lives in this one record.
    typedef struct packed {
        seq_state_t state;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] key;
        logic [7:0] asel;
        logic [31:0] src;
        logic [31:0] dst;
        logic [7:0] blk;
        logic [7:0] result;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic op_erase;
        logic cfg_changed;
        logic start;
    } core_t;

    core_t r; // Registered state.
    core_t next_r; // Next state.
    logic access; // A bus request is taken this cycle.
    logic wr; // Taken request is a write.
    logic rd; // Taken request is a read.
    logic src_in; // Source address inside flash.
    logic dst_in; // Destination address inside flash.
    logic src_bad; // Source address error.
    logic dst_bad; // Destination range or alignment error.
    logic key_bad; // Key register does not hold the valid key.
    logic blk_bad; // Erase block number out of range.
    logic boot_sel; // Boot array selected.
    logic [7:0] prog_res; // Result byte in the programming layout.
    logic [7:0] erase_res; // Result byte in the erasure layout.
    logic [31:0] rmux; // Read data before it is registered.

    // ------------------------------------------------------------
    // Address checks
    // ------------------------------------------------------------
    addr_window_check u_src_check (
        .addr(r.src),
        .in_flash(src_in)
    );

    addr_window_check u_dst_check (
        .addr(r.dst),
        .in_flash(dst_in)
    );

    // Byte-lane merge for word registers written over the bus.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Check results, built in both layouts
    // ------------------------------------------------------------
    // The unused positions are constant zero so they can never leak a stale flag.
    always_comb begin
        key_bad = (r.key != KEY_VALID);
        src_bad = !src_in;
        dst_bad = !dst_in || ((r.dst[7:0] != ALIGN_LOW_A) &&
                             (r.dst[7:0] != ALIGN_LOW_B));
        blk_bad = (r.blk >= ERASE_BLOCK_COUNT);
        boot_sel = (r.asel == ARRAY_SELECT_BOOT);
        prog_res = RESET_BYTE;
        prog_res[RES_PROTECT_BIT] = protect_error_flag;
        prog_res[RES_KEY_BIT] = key_bad;
        prog_res[RES_SOURCE_BIT] = src_bad;
        prog_res[RES_DEST_BIT] = dst_bad;
        prog_res[RES_SF_BIT] = |prog_res[7:1];
        erase_res = RESET_BYTE;
        erase_res[RES_PROTECT_BIT] = protect_error_flag;
        erase_res[RES_EXEC_BIT] = boot_sel;
        erase_res[RES_KEY_BIT] = key_bad;
        erase_res[RES_BLOCK_BIT] = blk_bad;
        erase_res[RES_SF_BIT] = |erase_res[7:1];
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // Unmapped addresses answer with zero data and a normal acknowledge.
    always_comb begin
        rmux = RESET_WORD;
        case (wb_adr_i)
            OFF_CONTROL: rmux[0] = (r.state != ST_IDLE);
            OFF_KEY: rmux[7:0] = r.key;
            OFF_ARRAY_SELECT: rmux[7:0] = r.asel;
            OFF_SOURCE_ADDR: rmux = r.src;
            OFF_DEST_ADDR: rmux = r.dst;
            OFF_ERASE_BLOCK: rmux[7:0] = r.blk;
            OFF_RESULT: rmux[7:0] = r.result;
            OFF_IRQ_STATUS: rmux[1:0] = r.irq_stat;
            OFF_IRQ_MASK: rmux[1:0] = r.irq_mask;
            default: rmux = RESET_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic: bus slave first, sequencer second
    // ------------------------------------------------------------
    // The sequencer runs after the bus part, so a status bit set in the
    // same cycle as a clearing read survives.
    always_comb begin
        next_r = r;
        next_r.start = 1'b0;
        access = wb_cyc_i && wb_stb_i && !r.ack;
        wr = access && wb_we_i;
        rd = access && !wb_we_i;
        next_r.ack = access;
        if (rd) begin
            next_r.rdata = rmux;
            if (wb_adr_i == OFF_IRQ_STATUS) begin
                next_r.irq_stat = 2'h0;
            end
        end
        if (wr) begin
            case (wb_adr_i)
                OFF_CONTROL: begin
                    // Commands are only accepted while idle; erase wins over program.
                    if (r.state == ST_IDLE && wb_sel_i[0] &&
                        (wb_dat_i[CTRL_PROGRAM_BIT] || wb_dat_i[CTRL_ERASE_BIT])) begin
                        next_r.state = ST_CHECK;
                        next_r.op_erase = wb_dat_i[CTRL_ERASE_BIT];
                        next_r.cfg_changed = 1'b0;
                    end
                end
                OFF_KEY: if (wb_sel_i[0]) next_r.key = wb_dat_i[7:0];
                OFF_ARRAY_SELECT: if (wb_sel_i[0]) next_r.asel = wb_dat_i[7:0];
                OFF_SOURCE_ADDR: next_r.src = merge(r.src, wb_dat_i, wb_sel_i);
                OFF_DEST_ADDR: next_r.dst = merge(r.dst, wb_dat_i, wb_sel_i);
                OFF_ERASE_BLOCK: if (wb_sel_i[0]) next_r.blk = wb_dat_i[7:0];
                OFF_IRQ_MASK: if (wb_sel_i[0]) next_r.irq_mask = wb_dat_i[1:0];
                default: begin
                    // Writes elsewhere are acknowledged and dropped.
                end
            endcase
            // A setting changed under a running operation spoils an erase; a program ignores it.
            if (r.state != ST_IDLE && wb_adr_i != OFF_CONTROL &&
                wb_adr_i != OFF_IRQ_MASK && wb_adr_i != OFF_IRQ_STATUS &&
                wb_adr_i != OFF_RESULT) begin
                next_r.cfg_changed = 1'b1;
            end
        end
        case (r.state)
            ST_IDLE: begin
                // Waiting for a command.
            end
            ST_CHECK: begin
                // All checks are made before the array is touched.
                next_r.result = r.op_erase ? erase_res : prog_res;
                if (r.op_erase ? erase_res[RES_SF_BIT] : prog_res[RES_SF_BIT]) begin
                    next_r.state = ST_DONE;
                end else begin
                    next_r.start = 1'b1;
                    next_r.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (flash_done) begin
                    if (r.op_erase) begin
                        // A failed erase may leave the array partly erased;
                        // software must erase again once the cause is gone.
                        next_r.result[RES_EXEC_BIT] = flash_fail || r.cfg_changed;
                        next_r.result[RES_SF_BIT] = flash_fail || r.cfg_changed;
                    end else begin
                        next_r.result[RES_SF_BIT] = flash_fail;
                    end
                    next_r.state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_r.irq_stat[IRQ_DONE_BIT] = 1'b1;
                if (r.result[RES_SF_BIT]) begin
                    next_r.irq_stat[IRQ_FAIL_BIT] = 1'b1;
                end
                next_r.state = ST_IDLE;
            end
            default: next_r.state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '{state: ST_IDLE, ack: 1'b0, rdata: RESET_WORD, key: RESET_BYTE,
                   asel: RESET_BYTE, src: RESET_WORD, dst: RESET_WORD,
                   blk: RESET_BYTE, result: RESET_BYTE, irq_stat: 2'h0,
                   irq_mask: 2'h0, op_erase: 1'b0, cfg_changed: 1'b0, start: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign flash_start = r.start;
    assign flash_erase = r.op_erase;
    assign flash_dest = r.dst;
    assign flash_src = r.src;
    assign flash_block = r.blk;
    assign prog_erase_result_flags = r.result;
    assign busy = (r.state != ST_IDLE);
    // Level interrupt, high while any unmasked status bit is set.
    assign irq = |(r.irq_stat & r.irq_mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_KEY_PROG: assert property (r.state == ST_CHECK && !r.op_erase |=>
        r.result[RES_KEY_BIT] == ($past(r.key) != KEY_VALID))
        else $error("program key flag wrong");
    AST_SRC_PROG: assert property (r.state == ST_CHECK && !r.op_erase |=>
        r.result[RES_SOURCE_BIT] == !($past(r.src) inside {[FLASH_BASE:FLASH_LIMIT]}))
        else $error("source address flag wrong");
    AST_DST_RANGE: assert property (r.state == ST_CHECK && !r.op_erase && !dst_in |=>
        r.result[RES_DEST_BIT] && r.state == ST_DONE)
        else $error("destination range flag missing");
    AST_DST_ALIGN: assert property (r.state == ST_CHECK && !r.op_erase &&
        r.dst[7:0] != ALIGN_LOW_A && r.dst[7:0] != ALIGN_LOW_B |=> r.result[RES_DEST_BIT])
        else $error("destination alignment flag missing");
    AST_SF_PROG: assert property (r.state == ST_RUN && !r.op_erase && flash_done |=>
        r.result[RES_SF_BIT] == $past(flash_fail) ##1 r.irq_stat[IRQ_DONE_BIT])
        else $error("program outcome wrong");
    AST_ERASE_LAYOUT: assert property (r.state == ST_DONE && r.op_erase |->
        !r.result[7] && r.result[2:1] == 2'h0)
        else $error("erase layout unused bits set");
    AST_PROTECT: assert property (r.state == ST_CHECK && r.op_erase |=>
        r.result[RES_PROTECT_BIT] == $past(protect_error_flag))
        else $error("protection flag not mirrored");
    AST_EXEC: assert property (r.state == ST_RUN && r.op_erase && flash_done &&
        (flash_fail || r.cfg_changed) |=> r.result[RES_EXEC_BIT])
        else $error("execution error not flagged");
    AST_BOOT: assert property (r.state == ST_CHECK && r.op_erase && boot_sel |=>
        r.result[RES_EXEC_BIT] && !r.start [*2])
        else $error("boot array erase not refused");
    AST_SF_ERASE: assert property (r.state == ST_DONE && r.op_erase |->
        r.result[RES_SF_BIT] == (|r.result[6:3]))
        else $error("erase outcome wrong");
    AST_KEY_ERASE: assert property (r.state == ST_CHECK && r.op_erase |=>
        r.result[RES_KEY_BIT] == ($past(r.key) != KEY_VALID))
        else $error("erase key flag wrong");
    AST_BLOCK: assert property (r.state == ST_CHECK && r.op_erase |=>
        r.result[RES_BLOCK_BIT] == ($past(r.blk) >= ERASE_BLOCK_COUNT))
        else $error("erase block flag wrong");
    AST_PROG_UNUSED: assert property (r.state == ST_DONE && !r.op_erase |->
        !r.result[7] && !r.result[3])
        else $error("program layout unused bits set");
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge timing wrong");

    COV_PROG_OK: cover property (r.state == ST_DONE && !r.op_erase && !r.result[RES_SF_BIT]);
    COV_ERASE_FAIL: cover property (r.state == ST_DONE && r.op_erase && r.result[RES_SF_BIT]);
    COV_IRQ: cover property (irq ##1 !irq);

endmodule

//--- testbench/flash_result_flags_tb_top.sv
`timescale 1ns/1ps

module flash_result_flags_tb_top
    import flash_result_pkg::*;
;
    // Stimulus and observed signals of the block.
    logic mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    logic protect_error_flag, flash_done, flash_fail, flash_start, flash_erase, busy, irq;
    logic [31:0] flash_dest, flash_src;
    logic [7:0] flash_block, prog_erase_result_flags;
    // Run bookkeeping and the interrupt mask the bench last wrote.
    int err_total;
    int comparisons;
    logic [1:0] mask;

    flash_result_flags dut_u (
        .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .protect_error_flag(protect_error_flag),
        .flash_done(flash_done), .flash_fail(flash_fail), .flash_start(flash_start),
        .flash_erase(flash_erase), .flash_dest(flash_dest), .flash_src(flash_src),
        .flash_block(flash_block), .prog_erase_result_flags(prog_erase_result_flags),
        .busy(busy), .irq(irq)
    );

    // ------------------------------------------------------------
    // Clock and shared tasks
    // ------------------------------------------------------------
    // The 40 MHz clock, 25 ns period.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation, four-state exact.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic Wishbone cycle; held until ack is sampled high at a rising edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        chk("bus_ack", 32'(wb_ack_o), 32'h0000_0001);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0000_0000, q);
    endtask

    // Sets up and runs one command, plays the array side, then checks the
    // result byte, the start pulse, the interrupt line and the status clear.
    task automatic op(input string nm, input logic e, input logic [7:0] k,
                      input logic [7:0] asel, input logic [31:0] src, input logic [31:0] dst,
                      input logic [7:0] blk, input logic f, input logic poke,
                      input logic st_exp, input logic [7:0] exp);
        logic [31:0] q;
        logic started;
        int n;
        started = 1'b0;
        n = 0;
        wr(OFF_KEY, {24'h00_0000, k});
        wr(OFF_ARRAY_SELECT, {24'h00_0000, asel});
        wr(OFF_SOURCE_ADDR, src);
        wr(OFF_DEST_ADDR, dst);
        wr(OFF_ERASE_BLOCK, {24'h00_0000, blk});
        // The mid-run poke case sets both command bits, where erase must win.
        wr(OFF_CONTROL, 32'({e, !e || poke}));
        do begin
            @(negedge mclk);
            n++;
            if (flash_start === 1'b1) begin
                started = 1'b1;
                chk("erase_kind", 32'(flash_erase), 32'(e));
                chk("src_port", flash_src, src);
                chk("dest_port", flash_dest, dst);
                chk("block_port", 32'(flash_block), 32'(blk));
                // A register write in mid-run, even of the same key, must spoil an erase outcome, and a
                // new command while busy must be ignored.
                if (poke) begin
                    wr(OFF_KEY, {24'h00_0000, k});
                    wr(OFF_CONTROL, 32'h0000_0001);
                    rd(OFF_CONTROL, q);
                    chk("busy_reg", q, 32'h0000_0001);
                    chk("erase_kept", 32'(flash_erase), 32'(e));
                end
                @(posedge mclk);
                flash_done <= 1'b1;
                flash_fail <= f;
                @(posedge mclk);
                flash_done <= 1'b0;
                flash_fail <= 1'b0;
            end
        end while (busy !== 1'b0 && n < 40);
        chk("idle", 32'(busy), 32'h0000_0000);
        chk("start_seen", 32'(started), 32'(st_exp));
        chk("result_port", 32'(prog_erase_result_flags), 32'(exp));
        chk("irq_level", 32'(irq), 32'(|(mask & {exp[0], 1'b1})));
        rd(OFF_RESULT, q);
        chk("result_reg", q, {24'h00_0000, exp});
        rd(OFF_IRQ_STATUS, q);
        chk("irq_status", q, 32'({exp[0], 1'b1}));
        @(negedge mclk);
        chk("irq_cleared", 32'(irq), 32'h0000_0000);
        $display("test %s done", nm);
    endtask

    // ------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------
    // 16 commands of under 60 cycles each; the limit leaves ample slack.
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        conclude();
    end

    initial begin
        logic [31:0] q;
        {wb_cyc_i, wb_stb_i, wb_we_i, protect_error_flag, flash_done, flash_fail} = '0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'h0;
        mask = 2'b00;
        err_total = 0;
        comparisons = 0;
        reset = 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(OFF_RESULT, q);
        chk("result_reset", q, 32'h0000_0000);
        wr(8'h3C, 32'h0000_00FF);
        rd(8'h3C, q);
        chk("unmapped", q, 32'h0000_0000);
        $display("test reset_and_map done");
        // Programming layout, masked interrupts first.
        op("p_bad_key", 0, 8'h5B, 0, 32'h100, 32'h80, 0, 0, 0, 0, 8'h11);
        op("p_ok", 0, KEY_VALID, 0, 32'h100, 32'h80, 0, 0, 0, 1, 8'h00);
        mask = 2'b01;
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        op("p_src_out", 0, KEY_VALID, 0, 32'h4_0000, 32'h80, 0, 0, 0, 0, 8'h05);
        op("p_dst_out", 0, KEY_VALID, 0, 32'h100, 32'h4_0000, 0, 0, 0, 0, 8'h03);
        op("p_dst_align", 0, KEY_VALID, 0, 32'h100, 32'h140, 0, 0, 0, 0, 8'h03);
        op("p_fail", 0, KEY_VALID, 0, 32'h3_FF00, 32'h100, 0, 1, 0, 1, 8'h01);
        @(posedge mclk);
        protect_error_flag <= 1'b1;
        op("p_protect", 0, KEY_VALID, 0, 32'h100, 32'h80, 0, 0, 0, 0, 8'h41);
        // Erasure layout; only failures reach the interrupt line now.
        mask = 2'b10;
        wr(OFF_IRQ_MASK, 32'h0000_0002);
        op("e_protect", 1, KEY_VALID, 0, 0, 0, 8'h00, 0, 0, 0, 8'h41);
        @(posedge mclk);
        protect_error_flag <= 1'b0;
        op("e_ok", 1, KEY_VALID, 0, 0, 0, 8'h0F, 0, 0, 1, 8'h00);
        op("e_block", 1, KEY_VALID, 0, 0, 0, 8'h10, 0, 0, 0, 8'h09);
        op("e_bad_key", 1, 8'h00, 0, 0, 0, 8'h03, 0, 0, 0, 8'h11);
        op("e_key_block", 1, 8'hA5, 0, 0, 0, 8'hFF, 0, 0, 0, 8'h19);
        op("e_boot", 1, KEY_VALID, ARRAY_SELECT_BOOT, 0, 0, 8'h01, 0, 0, 0, 8'h21);
        op("e_fail", 1, KEY_VALID, 0, 0, 0, 8'h02, 1, 0, 1, 8'h21);
        op("e_retry", 1, KEY_VALID, 0, 0, 0, 8'h02, 0, 0, 1, 8'h00);
        op("e_poke", 1, KEY_VALID, 0, 0, 0, 8'h04, 0, 1, 1, 8'h21);
        conclude();
    end
endmodule
